// ### verilog/redriver_pkg.sv
/*
 * Constants shared by the redriver configuration block and its serial target.
 * Assumes a single 125 MHz clock domain; pins arrive asynchronous.
 */
package redriver_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] OFS_GENERAL = 8'h00;
	localparam logic [7:0] OFS_ROUTE = 8'h01;
	localparam logic [7:0] OFS_PORT_A_CONTROL = 8'h02;
	localparam logic [7:0] OFS_PORT_A_INPUT = 8'h03;
	localparam logic [7:0] OFS_PORT_A_OUTPUT = 8'h04;
	localparam logic [7:0] OFS_PORT_B_CONTROL = 8'h06;
	localparam logic [7:0] OFS_PORT_B_INPUT = 8'h07;
	localparam logic [7:0] OFS_PORT_B_OUTPUT = 8'h08;
	localparam logic [7:0] OFS_PORT_C_CONTROL = 8'h0A;
	localparam logic [7:0] OFS_PORT_C_INPUT = 8'h0B;
	localparam logic [7:0] OFS_PORT_C_OUTPUT = 8'h0C;
	localparam logic [7:0] OFS_POLARITY_AB = 8'h10;
	localparam logic [7:0] OFS_POLARITY_C = 8'h11;
	localparam logic [7:0] OFS_LANE_ENABLE = 8'h12;
	localparam logic [7:0] OFS_LAST = 8'h12;
	localparam int REG_COUNT = 19;
	localparam int PORT_STRIDE = 4;

	// ************************************************************
	// Writable bit masks and reset values
	// ************************************************************
	localparam logic [7:0] MASK_GENERAL = 8'hC0;
	localparam logic [7:0] MASK_ROUTE = 8'hFF;
	localparam logic [7:0] MASK_CONTROL = 8'hF9;
	localparam logic [7:0] MASK_INPUT = 8'h8F;
	localparam logic [7:0] MASK_OUTPUT = 8'h33;
	localparam logic [7:0] MASK_POLARITY_AB = 8'hFF;
	localparam logic [7:0] MASK_POLARITY_C = 8'h0F;
	localparam logic [7:0] MASK_LANE_ENABLE = 8'h0F;
	localparam logic [7:0] RESET_LANE_ENABLE = 8'h0F;
	localparam logic [7:0] RESET_OTHER = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_POWER_DOWN = 6;
	localparam int BIT_DIAG = 7;
	localparam int POS_LOOP = 4;
	localparam int BIT_AGC_OFF = 0;
	localparam int BIT_SQUELCH = 3;
	localparam int POS_OUT_OFF = 4;
	localparam int BIT_INPUT_OFF = 7;
	localparam int BIT_PEAK_TOP = 3;
	localparam int BIT_UNITY_GAIN = 0;
	localparam int POS_SWING = 4;
	localparam logic [1:0] SWING_LOW_CODE = 2'h1;
	localparam int POS_POLARITY_B = 4;

	// ************************************************************
	// Strap vector layout and pin levels
	// ************************************************************
	localparam int ST_LANE = 0;
	localparam int ST_PEAK = 4;
	localparam int ST_ATT = 16;
	localparam int ST_SWING = 19;
	localparam int ST_AGC = 22;
	localparam int ST_SQUELCH = 25;
	localparam int ST_SEL = 26;
	localparam int ST_LOOP = 30;
	localparam int ST_DIAG = 33;
	localparam int ST_MODE = 34;
	localparam int ST_PDN = 35;
	localparam int ST_ID = 36;
	localparam int STRAP_W = 39;
	localparam logic [1:0] TRIT_LOW = 2'h0;
	localparam logic [1:0] TRIT_FLOAT = 2'h1;
	localparam logic [1:0] TRIT_HIGH = 2'h2;
	localparam logic [3:0] TRIT_WEIGHT = 4'h3;

	// ************************************************************
	// Output sources and bus framing
	// ************************************************************
	localparam logic [1:0] SRC_IDLE = 2'h0;
	localparam logic [1:0] SRC_A = 2'h1;
	localparam logic [1:0] SRC_B = 2'h2;
	localparam logic [1:0] SRC_C = 2'h3;
	localparam logic [3:0] BUS_ID_PREFIX = 4'h0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

endpackage : redriver_pkg

// ### verilog/serial_target.sv
/*
 * Two-wire serial target: start/stop detection, address match, offset
 * pointer, byte writes and reads with auto-increment.
 * Assumes the bus clock is far slower than clk_in; pins are asynchronous.
 */
`timescale 1ns/1ps
module serial_target (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic enable_in,
	input wire logic [2:0] bus_id_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic wr_out,
	output logic [7:0] addr_out,
	output logic [7:0] wr_data_out,
	input wire logic [7:0] rd_data_in
);

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ACK_ADDR = 9'h004,
		ST_OFFSET = 9'h008,
		ST_ACK_OFFSET = 9'h010,
		ST_WDATA = 9'h020,
		ST_ACK_WDATA = 9'h040,
		ST_RDATA = 9'h080,
		ST_RACK = 9'h100
	} bus_state_e;

	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		bus_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic acked;
		logic oe;
		logic wr;
		logic [7:0] wdata;
	} target_s;

	target_s s_q;
	target_s s_d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// ************************************************************
	// Bus sequencing
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.scl_sync = {s_q.scl_sync[1:0], scl_in};
		s_d.sda_sync = {s_q.sda_sync[1:0], sda_in};
		s_d.wr = 1'b0;
		// Edges look at stages two and three only
		scl_rise = s_q.scl_sync[1] & ~s_q.scl_sync[2];
		scl_fall = ~s_q.scl_sync[1] & s_q.scl_sync[2];
		start_seen = s_q.scl_sync[1] & s_q.scl_sync[2] & ~s_q.sda_sync[1] & s_q.sda_sync[2];
		stop_seen = s_q.scl_sync[1] & s_q.scl_sync[2] & s_q.sda_sync[1] & ~s_q.sda_sync[2];
		if (clear_in || !enable_in) begin
			s_d.st = ST_IDLE;
			s_d.oe = 1'b0;
			s_d.ptr = 8'h00;
		end else if (start_seen) begin
			s_d.st = ST_ADDR;
			s_d.cnt = 4'h0;
			s_d.oe = 1'b0;
		end else if (stop_seen) begin
			s_d.st = ST_IDLE;
			s_d.oe = 1'b0;
		end else if (scl_rise) begin
			case (s_q.st)
				ST_ADDR, ST_OFFSET, ST_WDATA: begin
					s_d.sh = {s_q.sh[6:0], s_q.sda_sync[1]};
					s_d.cnt = s_q.cnt + 4'h1;
				end
				ST_RDATA: begin
					s_d.cnt = s_q.cnt + 4'h1;
				end
				ST_RACK: begin
					s_d.acked = ~s_q.sda_sync[1];
					if (!s_q.sda_sync[1]) begin
						s_d.ptr = s_q.ptr + 8'h01;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (s_q.st)
				ST_ADDR: begin
					if (s_q.cnt == redriver_pkg::BITS_PER_BYTE) begin
						// Silent on a foreign address, bus left high
						if (s_q.sh[7:1] == {redriver_pkg::BUS_ID_PREFIX, bus_id_in}) begin
							s_d.oe = 1'b1;
							s_d.rw = s_q.sh[0];
							s_d.st = ST_ACK_ADDR;
						end else begin
							s_d.st = ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					s_d.cnt = 4'h0;
					if (s_q.rw) begin
						s_d.sh = rd_data_in;
						s_d.oe = ~rd_data_in[7];
						s_d.st = ST_RDATA;
					end else begin
						s_d.oe = 1'b0;
						s_d.st = ST_OFFSET;
					end
				end
				ST_OFFSET: begin
					if (s_q.cnt == redriver_pkg::BITS_PER_BYTE) begin
						s_d.ptr = s_q.sh;
						s_d.oe = 1'b1;
						s_d.st = ST_ACK_OFFSET;
					end
				end
				ST_WDATA: begin
					if (s_q.cnt == redriver_pkg::BITS_PER_BYTE) begin
						s_d.wr = 1'b1;
						s_d.wdata = s_q.sh;
						s_d.oe = 1'b1;
						s_d.st = ST_ACK_WDATA;
					end
				end
				ST_ACK_OFFSET, ST_ACK_WDATA: begin
					if (s_q.st == ST_ACK_WDATA) begin
						s_d.ptr = s_q.ptr + 8'h01;
					end
					s_d.oe = 1'b0;
					s_d.cnt = 4'h0;
					s_d.st = ST_WDATA;
				end
				ST_RDATA: begin
					if (s_q.cnt == redriver_pkg::BITS_PER_BYTE) begin
						s_d.oe = 1'b0;
						s_d.st = ST_RACK;
					end else begin
						s_d.sh = {s_q.sh[6:0], 1'b0};
						s_d.oe = ~s_q.sh[6];
					end
				end
				ST_RACK: begin
					if (s_q.acked) begin
						s_d.sh = rd_data_in;
						s_d.oe = ~rd_data_in[7];
						s_d.cnt = 4'h0;
						s_d.st = ST_RDATA;
					end else begin
						s_d.st = ST_IDLE;
					end
				end
				default: begin
					s_d.st = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '{scl_sync: 3'h7, sda_sync: 3'h7, st: ST_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = s_q.oe;
	assign wr_out = s_q.wr;
	assign addr_out = s_q.ptr;
	assign wr_data_out = s_q.wdata;

endmodule : serial_target

// ### verilog/redriver_config_and_routing_control.sv
/*
 * Configuration and routing control of a quad-lane three-port redriver:
 * strap or register sourced settings, per-lane routing and idle handling.
 * Assumes straps are quasi-static; all pins are asynchronous to clk_in.
 */
// Operation
// - Power-down pin off inputs, outputs, bus
// - General bit six powers down inputs, outputs, not bus
// - Per-lane enable for every port
// - Register peaking code to nine steps
// - Three-level pin pair to same steps
// - Bit zero or pin picks attenuation
// - Swing code one low, else high
// - Auto gain enabled when bit is zero
// - Select pin chooses straps or registers
// - Output-off, input-off, polarity only registers
// - Bus address low bits from pins
// - Idle outputs disabled or squelched
// - Input-off bit powers whole port input
// - Control high nibble disables output lanes
// - Per-lane polarity inversion from registers
// - Port C lane goes to A or B
// - Port loopback sends input back out
// - Diagnostic sends C input to A, B
// - Address four zeros plus pin bits
// - Start, address, offset, data, stop framing
`timescale 1ns/1ps
module redriver_config_and_routing_control #(
	parameter int LANES = 4,
	parameter int PORTS = 3
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic power_good_n_in,
	input wire logic register_mode_in,
	input wire logic [2:0] bus_id_pins_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [3:0] lane_on_pin_in,
	input wire logic [11:0] peaking_level_pins_in,
	input wire logic [2:0] input_attenuation_pin_in,
	input wire logic [2:0] output_swing_range_pin_in,
	input wire logic [2:0] auto_gain_off_in,
	input wire logic idle_output_squelch_in,
	input wire logic [3:0] lane_route_choice_in,
	input wire logic [2:0] port_loopback_on_in,
	input wire logic diag_pin_in,
	output logic power_down_out,
	output logic [3:0] lane_enable_out,
	output logic [11:0] peaking_step_out,
	output logic [2:0] unity_gain_out,
	output logic [2:0] swing_high_out,
	output logic [2:0] agc_enable_out,
	output logic [2:0] input_off_out,
	output logic [11:0] polarity_invert_out,
	output logic [23:0] out_source_out,
	output logic [11:0] out_squelch_out,
	output logic [11:0] out_off_out
);

	typedef struct packed {
		logic [redriver_pkg::STRAP_W-1:0] strap1;
		logic [redriver_pkg::STRAP_W-1:0] strap2;
		logic [redriver_pkg::REG_COUNT-1:0][7:0] regs;
		logic power_down;
		logic [3:0] lane_enable;
		logic [11:0] peaking;
		logic [2:0] unity_gain;
		logic [2:0] swing_high;
		logic [2:0] agc_enable;
		logic [2:0] input_off;
		logic [11:0] polarity;
		logic [23:0] source;
		logic [11:0] squelch;
		logic [11:0] off;
	} ctrl_s;

	ctrl_s s_q;
	ctrl_s s_d;
	logic bus_wr;
	logic [7:0] bus_addr;
	logic [7:0] bus_wdata;
	logic [7:0] bus_rdata;
	logic pins_ok;
	logic reg_mode;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [7:0] reg_mask(input logic [7:0] a);
		logic [7:0] m;
		m = 8'h00;
		case (a)
			redriver_pkg::OFS_GENERAL: m = redriver_pkg::MASK_GENERAL;
			redriver_pkg::OFS_ROUTE: m = redriver_pkg::MASK_ROUTE;
			redriver_pkg::OFS_PORT_A_CONTROL,
			redriver_pkg::OFS_PORT_B_CONTROL,
			redriver_pkg::OFS_PORT_C_CONTROL: m = redriver_pkg::MASK_CONTROL;
			redriver_pkg::OFS_PORT_A_INPUT,
			redriver_pkg::OFS_PORT_B_INPUT,
			redriver_pkg::OFS_PORT_C_INPUT: m = redriver_pkg::MASK_INPUT;
			redriver_pkg::OFS_PORT_A_OUTPUT,
			redriver_pkg::OFS_PORT_B_OUTPUT,
			redriver_pkg::OFS_PORT_C_OUTPUT: m = redriver_pkg::MASK_OUTPUT;
			redriver_pkg::OFS_POLARITY_AB: m = redriver_pkg::MASK_POLARITY_AB;
			redriver_pkg::OFS_POLARITY_C: m = redriver_pkg::MASK_POLARITY_C;
			redriver_pkg::OFS_LANE_ENABLE: m = redriver_pkg::MASK_LANE_ENABLE;
			default: m = 8'h00;
		endcase
		return m;
	endfunction : reg_mask

	function automatic logic [3:0] peak_from_code(input logic [3:0] code);
		// Top bit clear collapses to the minimum step
		return code[redriver_pkg::BIT_PEAK_TOP] ? {1'b0, code[2:0]} + 4'h1 : 4'h0;
	endfunction : peak_from_code

	function automatic logic [3:0] trit_value(input logic [1:0] t);
		logic [3:0] v;
		v = 4'h0;
		case (t)
			redriver_pkg::TRIT_FLOAT: v = 4'h1;
			redriver_pkg::TRIT_HIGH: v = 4'h2;
			default: v = 4'h0;
		endcase
		return v;
	endfunction : trit_value

	function automatic logic [7:0] reg_read(input ctrl_s st, input logic [7:0] a);
		return (a <= redriver_pkg::OFS_LAST) ? (st.regs[a[4:0]] & reg_mask(a)) : 8'h00;
	endfunction : reg_read

	// ************************************************************
	// Serial target
	// ************************************************************
	assign pins_ok = s_q.strap2[redriver_pkg::ST_PDN];
	assign reg_mode = s_q.strap2[redriver_pkg::ST_MODE];
	assign bus_rdata = reg_read(s_q, bus_addr);

	serial_target u_target (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.clear_in(~pins_ok),
		.enable_in(reg_mode),
		.bus_id_in(s_q.strap2[redriver_pkg::ST_ID +: 3]),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_out(sda_oe_out),
		.wr_out(bus_wr),
		.addr_out(bus_addr),
		.wr_data_out(bus_wdata),
		.rd_data_in(bus_rdata)
	);

	// ************************************************************
	// Register file and configuration decode
	// ************************************************************
	always_comb begin
		logic [7:0] ctrl;
		logic [7:0] inset;
		logic [7:0] outset;
		logic [7:0] route;
		logic [3:0] sel;
		logic [2:0] loop;
		logic diag;
		logic squelch_sel;
		logic [1:0] src;
		logic [7:0] pol;
		int base;
		ctrl = 8'h00;
		inset = 8'h00;
		outset = 8'h00;
		route = 8'h00;
		sel = 4'h0;
		loop = 3'h0;
		diag = 1'b0;
		squelch_sel = 1'b0;
		src = redriver_pkg::SRC_IDLE;
		pol = 8'h00;
		base = 0;
		s_d = s_q;
		s_d.strap1 = {bus_id_pins_in, power_good_n_in, register_mode_in, diag_pin_in, port_loopback_on_in,
			lane_route_choice_in, idle_output_squelch_in, auto_gain_off_in, output_swing_range_pin_in,
			input_attenuation_pin_in, peaking_level_pins_in, lane_on_pin_in};
		s_d.strap2 = s_q.strap1;
		if (!pins_ok) begin
			for (int i = 0; i < redriver_pkg::REG_COUNT; i++) begin
				s_d.regs[i] = redriver_pkg::RESET_OTHER;
			end
			s_d.regs[redriver_pkg::OFS_LANE_ENABLE[4:0]] = redriver_pkg::RESET_LANE_ENABLE;
		end else if (bus_wr && bus_addr <= redriver_pkg::OFS_LAST) begin
			s_d.regs[bus_addr[4:0]] = bus_wdata & reg_mask(bus_addr);
		end
		route = s_q.regs[redriver_pkg::OFS_ROUTE[4:0]];
		if (reg_mode) begin
			sel = route[3:0];
			loop = route[redriver_pkg::POS_LOOP +: 3];
			diag = route[redriver_pkg::BIT_DIAG];
			s_d.lane_enable = s_q.regs[redriver_pkg::OFS_LANE_ENABLE[4:0]][3:0];
			s_d.power_down = ~pins_ok |
				s_q.regs[redriver_pkg::OFS_GENERAL[4:0]][redriver_pkg::BIT_POWER_DOWN];
		end else begin
			sel = s_q.strap2[redriver_pkg::ST_SEL +: 4];
			loop = s_q.strap2[redriver_pkg::ST_LOOP +: 3];
			diag = s_q.strap2[redriver_pkg::ST_DIAG];
			s_d.lane_enable = s_q.strap2[redriver_pkg::ST_LANE +: 4];
			s_d.power_down = ~pins_ok;
		end
		pol = s_q.regs[redriver_pkg::OFS_POLARITY_AB[4:0]];
		for (int p = 0; p < PORTS; p++) begin
			base = int'(redriver_pkg::OFS_PORT_A_CONTROL) + p * redriver_pkg::PORT_STRIDE;
			ctrl = s_q.regs[base];
			inset = s_q.regs[base + 1];
			outset = s_q.regs[base + 2];
			if (reg_mode) begin
				s_d.peaking[p*4 +: 4] = peak_from_code(inset[3:0]);
				s_d.unity_gain[p] = outset[redriver_pkg::BIT_UNITY_GAIN];
				s_d.swing_high[p] = (outset[redriver_pkg::POS_SWING +: 2] != redriver_pkg::SWING_LOW_CODE);
				s_d.agc_enable[p] = ~ctrl[redriver_pkg::BIT_AGC_OFF];
				squelch_sel = ctrl[redriver_pkg::BIT_SQUELCH];
				s_d.input_off[p] = s_d.power_down | inset[redriver_pkg::BIT_INPUT_OFF];
			end else begin
				s_d.peaking[p*4 +: 4] = 4'((redriver_pkg::TRIT_WEIGHT *
					trit_value(s_q.strap2[redriver_pkg::ST_PEAK + p*4 + 2 +: 2])) +
					trit_value(s_q.strap2[redriver_pkg::ST_PEAK + p*4 +: 2]));
				s_d.unity_gain[p] = s_q.strap2[redriver_pkg::ST_ATT + p];
				s_d.swing_high[p] = s_q.strap2[redriver_pkg::ST_SWING + p];
				s_d.agc_enable[p] = ~s_q.strap2[redriver_pkg::ST_AGC + p];
				squelch_sel = s_q.strap2[redriver_pkg::ST_SQUELCH];
				s_d.input_off[p] = s_d.power_down;
			end
			for (int l = 0; l < LANES; l++) begin
				// Loopback overrides, then port C lane select, then diagnostic, then port A/B lane select
				if (loop[p]) begin
					src = (p == 0) ? redriver_pkg::SRC_A : (p == 1) ? redriver_pkg::SRC_B : redriver_pkg::SRC_C;
				end else if (p == 2) begin
					src = sel[l] ? redriver_pkg::SRC_B : redriver_pkg::SRC_A;
				end else if (diag) begin
					src = redriver_pkg::SRC_C;
				end else begin
					src = (sel[l] == (p == 1)) ? redriver_pkg::SRC_C : redriver_pkg::SRC_IDLE;
				end
				s_d.source[(p*LANES + l)*2 +: 2] = src;
				if (s_d.power_down || !s_d.lane_enable[l] ||
					(reg_mode && ctrl[redriver_pkg::POS_OUT_OFF + 3 - l])) begin
					s_d.off[p*LANES + l] = 1'b1;
					s_d.squelch[p*LANES + l] = 1'b0;
				end else begin
					s_d.off[p*LANES + l] = (src == redriver_pkg::SRC_IDLE) & ~squelch_sel;
					s_d.squelch[p*LANES + l] = (src == redriver_pkg::SRC_IDLE) & squelch_sel;
				end
				s_d.polarity[p*LANES + l] = 1'b0;
			end
		end
		if (reg_mode) begin
			s_d.polarity[3:0] = pol[3:0];
			s_d.polarity[7:4] = pol[redriver_pkg::POS_POLARITY_B +: 4];
			s_d.polarity[11:8] = s_q.regs[redriver_pkg::OFS_POLARITY_C[4:0]][3:0];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '{power_down: 1'b1, input_off: 3'h7, off: 12'hFFF, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign power_down_out = s_q.power_down;
	assign lane_enable_out = s_q.lane_enable;
	assign peaking_step_out = s_q.peaking;
	assign unity_gain_out = s_q.unity_gain;
	assign swing_high_out = s_q.swing_high;
	assign agc_enable_out = s_q.agc_enable;
	assign input_off_out = s_q.input_off;
	assign polarity_invert_out = s_q.polarity;
	assign out_source_out = s_q.source;
	assign out_squelch_out = s_q.squelch;
	assign out_off_out = s_q.off;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_pin_power_down;
		@(posedge clk_in) disable iff (rst_in)
		!pins_ok |=> power_down_out && (input_off_out == 3'h7) && (out_off_out == 12'hFFF);
	endproperty
	a_pin_power_down: assert property (p_pin_power_down) else $error("pin power-down not applied");

	property p_reg_power_down;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && s_q.regs[0][6] |=> power_down_out && (out_off_out == 12'hFFF);
	endproperty
	a_reg_power_down: assert property (p_reg_power_down) else $error("register power-down not applied");

	property p_lane_enable;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode ##1 reg_mode |-> lane_enable_out == $past(s_q.regs[18][3:0]);
	endproperty
	a_lane_enable: assert property (p_lane_enable) else $error("lane enable mismatch");

	property p_peak_reg;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && !s_q.regs[3][3] |=> peaking_step_out[3:0] == 4'h0;
	endproperty
	a_peak_reg: assert property (p_peak_reg) else $error("low peaking code not minimum");

	property p_peak_pins;
		@(posedge clk_in) disable iff (rst_in)
		!reg_mode && s_q.strap2[7:4] == 4'h5 |=> peaking_step_out[3:0] == 4'h4;
	endproperty
	a_peak_pins: assert property (p_peak_pins) else $error("floating pins not middle step");

	property p_swing;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && s_q.regs[4][5:4] == 2'h1 |=> !swing_high_out[0];
	endproperty
	a_swing: assert property (p_swing) else $error("swing low code ignored");

	property p_pin_polarity;
		@(posedge clk_in) disable iff (rst_in)
		!reg_mode |=> polarity_invert_out == 12'h000;
	endproperty
	a_pin_polarity: assert property (p_pin_polarity) else $error("polarity inverted in pin mode");

	property p_route_c;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && !s_q.regs[1][6] && s_q.regs[1][0] |=> out_source_out[17:16] == 2'h2;
	endproperty
	a_route_c: assert property (p_route_c) else $error("port C lane 0 not from B");

	property p_loop_a;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && s_q.regs[1][4] |=> out_source_out[7:0] == 8'h55;
	endproperty
	a_loop_a: assert property (p_loop_a) else $error("port A loopback not applied");

	property p_diag;
		@(posedge clk_in) disable iff (rst_in)
		reg_mode && s_q.regs[1][7] && s_q.regs[1][5:4] == 2'h0 |=> out_source_out[15:0] == 16'hFFFF;
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic routing missing");

endmodule : redriver_config_and_routing_control

// ### tb/i2c_master_model.sv
/* Two-wire bus master model: start, stop, byte transfers.
 * Assumes the bench resolves the open-drain data wire. */
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial begin
		scl_out = 1;
		sda_low_out = 0;
	end
	// Fast bus rate keeps the run short
	task automatic q;
		repeat (20) @(posedge clk_in);
		#1;
	endtask : q
	task automatic bit_io(input logic b, output logic r);
		sda_low_out = !b;
		q;
		scl_out = 1;
		q;
		r = sda_in;
		q;
		scl_out = 0;
		q;
	endtask : bit_io
	// Start when st, else stop; clock stands high after stop
	task automatic edge_pair(input logic st);
		sda_low_out = !st;
		q;
		scl_out = 1;
		q;
		sda_low_out = st;
		q;
		scl_out = !st;
		q;
	endtask : edge_pair
	task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] r, output logic a);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			r = {r[6:0], b};
		end
		bit_io(rel, a);
	endtask : xfer
endmodule : i2c_master_model

// ### tb/redriver_config_and_routing_control_tb_top.sv
/* Bench for the redriver control: straps, routing, serial registers.
 * Assumes the master model drives the bus pins. */
`timescale 1ns/1ps
module redriver_config_and_routing_control_tb_top;
	logic clk_in, rst_in, power_good_n_in, register_mode_in, scl_in, sda_in, sda_out, sda_oe_out, m_low, a;
	logic idle_output_squelch_in, diag_pin_in, power_down_out;
	logic [2:0] bus_id_pins_in, input_attenuation_pin_in, output_swing_range_pin_in, auto_gain_off_in;
	logic [2:0] port_loopback_on_in, unity_gain_out, swing_high_out, agc_enable_out, input_off_out;
	logic [3:0] lane_on_pin_in, lane_route_choice_in, lane_enable_out;
	logic [7:0] r;
	logic [11:0] peaking_level_pins_in, peaking_step_out, polarity_invert_out, out_squelch_out, out_off_out;
	logic [23:0] out_source_out;
	int n_errors = 0;
	int checks = 0;
	// Pull-up on the shared data wire
	assign sda_in = !(m_low || (sda_oe_out && !sda_out));
	redriver_config_and_routing_control dut_u (
		.clk_in(clk_in), .rst_in(rst_in), .power_good_n_in(power_good_n_in),
		.register_mode_in(register_mode_in), .bus_id_pins_in(bus_id_pins_in),
		.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
		.lane_on_pin_in(lane_on_pin_in), .peaking_level_pins_in(peaking_level_pins_in),
		.input_attenuation_pin_in(input_attenuation_pin_in), .output_swing_range_pin_in(output_swing_range_pin_in),
		.auto_gain_off_in(auto_gain_off_in), .idle_output_squelch_in(idle_output_squelch_in),
		.lane_route_choice_in(lane_route_choice_in), .port_loopback_on_in(port_loopback_on_in),
		.diag_pin_in(diag_pin_in), .power_down_out(power_down_out), .lane_enable_out(lane_enable_out),
		.peaking_step_out(peaking_step_out), .unity_gain_out(unity_gain_out), .swing_high_out(swing_high_out),
		.agc_enable_out(agc_enable_out), .input_off_out(input_off_out), .polarity_invert_out(polarity_invert_out),
		.out_source_out(out_source_out), .out_squelch_out(out_squelch_out), .out_off_out(out_off_out)
	);
	i2c_master_model m_u (.clk_in(clk_in), .sda_in(sda_in), .scl_out(scl_in), .sda_low_out(m_low));
	always #4 clk_in = !clk_in;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("n_errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		m_u.edge_pair(1);
		m_u.xfer({4'h0, bus_id_pins_in, 1'b0}, 1, r, a);
		chk(a, 1'h0);
		m_u.xfer(o, 1, r, a);
		m_u.xfer(d, 1, r, a);
		chk(a, 1'h0);
		m_u.edge_pair(0);
		tick(3);
	endtask : wr
	task automatic route(input logic [2:0] lp, input logic dg, input logic [3:0] sl, input logic sq);
		logic [23:0] s;
		logic [11:0] idle;
		{port_loopback_on_in, diag_pin_in, lane_route_choice_in, idle_output_squelch_in} = {lp, dg, sl, sq};
		for (int l = 0; l < 4; l++) begin
			s[l*2+:2] = lp[0] ? 2'h1 : dg ? 2'h3 : sl[l] ? 2'h0 : 2'h3;
			s[8+l*2+:2] = lp[1] ? 2'h2 : dg ? 2'h3 : sl[l] ? 2'h3 : 2'h0;
			s[16+l*2+:2] = lp[2] ? 2'h3 : sl[l] ? 2'h2 : 2'h1;
		end
		for (int i = 0; i < 12; i++)
			idle[i] = s[i*2+:2] == 2'h0;
		tick(4);
		chk(out_source_out, s);
		chk(out_off_out, sq ? 12'h0 : idle);
		chk(out_squelch_out, sq ? idle : 12'h0);
	endtask : route
	initial begin
		clk_in = 0;
		rst_in = 1;
		{power_good_n_in, register_mode_in, bus_id_pins_in, lane_on_pin_in} = {2'h2, 3'h5, 4'hF};
		{input_attenuation_pin_in, output_swing_range_pin_in, auto_gain_off_in, peaking_level_pins_in} = '0;
		{port_loopback_on_in, diag_pin_in, idle_output_squelch_in, lane_route_choice_in} = '0;
		tick(20);
		chk({power_down_out, input_off_out, out_off_out}, 16'hFFFF);
		rst_in = 0;
		{lane_on_pin_in, input_attenuation_pin_in, output_swing_range_pin_in, auto_gain_off_in} = 13'hCB6;
		tick(4);
		chk({lane_enable_out, unity_gain_out, swing_high_out, agc_enable_out}, 13'hCB1);
		{lane_on_pin_in, input_attenuation_pin_in, output_swing_range_pin_in, auto_gain_off_in} = 13'h1349;
		tick(4);
		chk({lane_enable_out, unity_gain_out, swing_high_out, agc_enable_out}, 13'h134E);
		chk({sda_out, sda_oe_out, polarity_invert_out, input_off_out}, 17'h0);
		lane_on_pin_in = 4'hF;
		for (int f = 0; f < 3; f++)
			for (int g = 0; g < 3; g++) begin
				peaking_level_pins_in = {3{f[1:0], g[1:0]}};
				tick(4);
				chk(peaking_step_out, {3{4'(f * 3 + g)}});
			end
		route(3'h0, 1'h0, 4'h5, 1'h1);
		route(3'h1, 1'h1, 4'h3, 1'h0);
		route(3'h6, 1'h0, 4'hA, 1'h1);
		route(3'h0, 1'h1, 4'hC, 1'h0);
		route(3'h0, 1'h0, 4'h0, 1'h0);
		register_mode_in = 1;
		tick(4);
		wr(8'h02, 8'h81);
		chk({agc_enable_out, out_off_out}, 15'h60F1);
		wr(8'h12, 8'h05);
		chk(lane_enable_out, 4'h5);
		wr(8'h03, 8'h87);
		wr(8'h07, 8'h08);
		wr(8'h0B, 8'h8F);
		chk({peaking_step_out, input_off_out}, 15'h4085);
		wr(8'h04, 8'h12);
		wr(8'h08, 8'h21);
		chk({unity_gain_out, swing_high_out}, 6'h16);
		wr(8'h10, 8'hA5);
		wr(8'h11, 8'hF3);
		chk(polarity_invert_out, 12'h3A5);
		wr(8'h01, 8'h81);
		chk(out_source_out, 24'h56FFFF);
		wr(8'h01, 8'h11);
		chk(out_source_out, 24'h560355);
		wr(8'h00, 8'h7F);
		chk(power_down_out, 1'h1);
		m_u.edge_pair(1);
		m_u.xfer(8'h0A, 1, r, a);
		m_u.xfer(8'h00, 1, r, a);
		m_u.edge_pair(1);
		m_u.xfer(8'h0B, 1, r, a);
		m_u.xfer(8'hFF, 1, r, a);
		chk(r, 8'h40);
		m_u.edge_pair(1);
		m_u.xfer(8'h02, 1, r, a);
		chk(a, 1'h1);
		m_u.edge_pair(0);
		register_mode_in = 0;
		tick(4);
		chk({power_down_out, polarity_invert_out}, 13'h0);
		power_good_n_in = 0;
		tick(4);
		chk({power_down_out, input_off_out, out_off_out}, 16'hFFFF);
		{power_good_n_in, register_mode_in, bus_id_pins_in} = 5'h1A;
		tick(4);
		chk({polarity_invert_out, lane_enable_out}, 16'h000F);
		wr(8'h11, 8'h0C);
		chk(polarity_invert_out, 12'hC00);
		final_report;
	end
	// About thirty-four thousand cycles of bus traffic expected
	initial begin
		repeat (60000) @(posedge clk_in);
		n_errors++;
		final_report;
	end
endmodule : redriver_config_and_routing_control_tb_top
